// ### rtl/rspc_map.svh
/*
 * Register offsets, field positions, reset values and timing constants for the
 * rail status and pin configuration register bank.
 * Assumes a 20 MHz core clock and an 8-bit register address space.
 */
`ifndef RSPC_MAP_SVH
`define RSPC_MAP_SVH

`define RSPC_OFS_RAIL_POK       8'h03
`define RSPC_OFS_CURRENT_LIMIT_EVT       8'h04
`define RSPC_OFS_RST_DELAY      8'h05
`define RSPC_OFS_PIN2_CFG       8'h06

`define RSPC_RAIL_LSB           2
`define RSPC_RAIL_MSB           7
`define RSPC_DLY_MSB            2
`define RSPC_P2_EN_BIT          7
`define RSPC_P2_SEL_MSB         6
`define RSPC_P2_SEL_LSB         3
`define RSPC_P2_LVL_MSB         1

`define RSPC_RST_DELAY_RESET    3'h4
`define RSPC_PIN2_CFG_RESET     8'h00

`define RSPC_CLK_HZ             20000000
`define RSPC_BASE_DELAY_US      500
`define RSPC_BASE_DELAY_CYC     ((`RSPC_BASE_DELAY_US * (`RSPC_CLK_HZ / 1000)) / 1000)

`endif

// ### rtl/rspc_pkg.sv
/*
 * Types shared by the register bank and its delay timer.
 * Assumes the map header supplies every numeric constant.
 */
package rspc_pkg;

    typedef enum logic [3:0] {
        RSPC_FN_GPO1     = 4'h0,
        RSPC_FN_GPO2     = 4'h1,
        RSPC_FN_IRQ      = 4'h2,
        RSPC_FN_SLEEP    = 4'h3,
        RSPC_FN_DSLEEP   = 4'h4,
        RSPC_FN_SW12_EN  = 4'h5,
        RSPC_FN_POWER_DISABLE_IN   = 4'h6,
        RSPC_FN_EXT_IN1  = 4'h7,
        RSPC_FN_EXT_IN2  = 4'h8
    } rspc_func_t;

    typedef enum {
        RSPC_ST_BAD,
        RSPC_ST_WAIT,
        RSPC_ST_GOOD
    } rspc_state_t;

endpackage

// ### rtl/rspc_dly_if.sv
/*
 * Interface joining the register bank to its reset-release timer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface rspc_dly_if;
    logic       start;
    logic       clear;
    logic [2:0] sel;
    logic       done;

    modport bank  (output start, output clear, output sel, input done);
    modport timer (input start, input clear, input sel, output done);
endinterface

// ### rtl/rspc_dly_timer.sv
/*
 * Reset-release delay timer: counts base periods of 0.5 ms, 2^sel of them.
 * Assumes start is held while the timed condition lasts and clear drops it.
 */
`timescale 1ns/1ps
`include "rspc_map.svh"

module rspc_dly_timer
    import rspc_pkg::*;
#(
    parameter int BASE_CYC = `RSPC_BASE_DELAY_CYC
) (
    input  wire logic  clk,
    input  wire logic  rst,
    rspc_dly_if.timer  dly
);

    logic [13:0] base_r;
    // Eight bits, so that the 128 periods of the longest code do not wrap to zero.
    logic [7:0]  periods_r;
    logic        done_r;
    wire         base_end = (base_r == 14'(BASE_CYC - 1));
    wire  [7:0]  target   = 8'(8'h01 << dly.sel);

    // Base-period prescaler and period counter; restart whenever cleared.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_r    <= 14'h0000;
            periods_r <= 8'h00;
            done_r    <= 1'b0;
        end else if (dly.clear || !dly.start) begin
            base_r    <= 14'h0000;
            periods_r <= 8'h00;
            done_r    <= 1'b0;
        end else if (!done_r) begin
            base_r <= base_end ? 14'h0000 : base_r + 14'h0001;
            if (base_end) begin
                periods_r <= periods_r + 8'h01;
                done_r    <= (periods_r + 8'h01) == target;
            end
        end
    end

    assign dly.done = done_r;

endmodule // rspc_dly_timer

// ### rtl/rspc_regs.sv
/*
 * Rail status and pin 2 configuration register bank with power-good reset
 * release sequencing.
 * Assumes a simple synchronous register port driven by the serial bus slave,
 * and rail power-ok and current-limit inputs synchronous to CLOCK.
 */
`timescale 1ns/1ps
`include "rspc_map.svh"

// How it works
// - Read-only rail status at 0x03, bits 7:2 rails, bits 1:0 reserved.
// - Status bits follow live rail power-ok with no latching.
// - Current-limit event register at 0x04 latches per-rail events in bits 7:2.
// - Reading the event register returns captured bits and clears them.
// - Three-bit delay field at 0x05 times all rails good to reset release.
// - Codes 000, 001, 010 give 0.5, 1 and 2 ms.
// - Codes 100, 110, 111 give 8, 32 and 64 ms.
// - Pin 2 keeps initial function until release; then bit 7 enables selection.
// - Select codes 0000 and 0001 make pin 2 external enable output 1 or 2.
// - Select code 0010 makes pin 2 the active-low interrupt output.
// - Codes 0011 and 0100 make pin 2 a sleep or deep sleep input.
// - Code 0101 gives rail 1/2 enable input, code 0110 power disable.
// - Codes 0111 and 1000 are not offered on pin 2.
// - Level field bits 1:0 drive general output low for 00, high for 01.
// - External enable output acts only after reset release.
// - Before release pins 2, 3, 4, 6 are voltage select inputs.
// - Power-good reset goes high after sequence with all rails good, else low.
module rspc_regs
    import rspc_pkg::*;
#(
    parameter int BASE_CYC = `RSPC_BASE_DELAY_CYC
) (
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    input  wire logic [7:0] REG_WDATA,
    output      logic [7:0] REG_RDATA,
    input  wire logic [5:0] RAIL_POWER_OK,
    input  wire logic [5:0] RAIL_CURRENT_LIMIT,
    input  wire logic       IRQ_PENDING,
    input  wire logic       PIN2_IN,
    output      logic       PIN2_OUT,
    output      logic       PIN2_OE_N,
    output      logic       POWER_GOOD_RESET_OUT,
    output      logic       RAIL_VOLTAGE_SELECT_MODE,
    output      logic       SLEEP_REQ,
    output      logic       DEEP_SLEEP_REQ,
    output      logic       SW_RAIL12_ENABLE,
    output      logic       POWER_DISABLE_IN
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.
    ////////////////////////////////////////////////////////////////////////////

    logic [5:0]  current_limit_evt_r;
    logic [5:0]  current_limit_evt_nxt;
    logic [2:0]  dly_sel_r;
    logic        p2_en_r;
    logic [3:0]  p2_sel_r;
    logic [1:0]  p2_lvl_r;
    logic [7:0]  rdata_r;
    logic [7:0]  rdata_nxt;
    rspc_state_t state_r;
    rspc_state_t state_nxt;

    // Register decodes.
    wire hit_pok   = (REG_ADDR == `RSPC_OFS_RAIL_POK);
    wire hit_current_limit  = (REG_ADDR == `RSPC_OFS_CURRENT_LIMIT_EVT);
    wire hit_dly   = (REG_ADDR == `RSPC_OFS_RST_DELAY);
    wire hit_p2    = (REG_ADDR == `RSPC_OFS_PIN2_CFG);
    wire rd_current_limit   = REG_RD && hit_current_limit;
    wire wr_dly    = REG_WR && hit_dly;
    wire wr_p2     = REG_WR && hit_p2;

    // Power-good state helpers.
    wire all_good  = &RAIL_POWER_OK;
    wire rail3_ok  = RAIL_POWER_OK[3];
    wire released  = (state_r == RSPC_ST_GOOD);

    ////////////////////////////////////////////////////////////////////////////
    // Current-limit event flags: new events win over a clearing read.
    ////////////////////////////////////////////////////////////////////////////

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_evt
            // Port bit 0 is linear rail 2, bit 5 is switching rail 1.
            assign current_limit_evt_nxt[gi] = RAIL_CURRENT_LIMIT[gi] |
                                      (current_limit_evt_r[gi] & ~rd_current_limit);
        end
    endgenerate

    // Event register update.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            current_limit_evt_r <= 6'h00;
        end else begin
            current_limit_evt_r <= current_limit_evt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers; reserved bits are never stored.
    ////////////////////////////////////////////////////////////////////////////

    // Writes to the delay field and pin 2 configuration.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            dly_sel_r <= `RSPC_RST_DELAY_RESET;
            p2_en_r   <= 1'b0;
            p2_sel_r  <= 4'h0;
            p2_lvl_r  <= 2'h0;
        end else begin
            if (wr_dly) begin
                dly_sel_r <= REG_WDATA[`RSPC_DLY_MSB:0];
            end
            if (wr_p2) begin
                p2_en_r  <= REG_WDATA[`RSPC_P2_EN_BIT];
                p2_sel_r <= REG_WDATA[`RSPC_P2_SEL_MSB:`RSPC_P2_SEL_LSB];
                p2_lvl_r <= REG_WDATA[`RSPC_P2_LVL_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data: registered, one cycle after the read strobe.
    ////////////////////////////////////////////////////////////////////////////

    // Read multiplexer; unmapped offsets and reserved bits read zero.
    always_comb begin
        rdata_nxt = 8'h00;
        if (REG_RD) begin
            if (hit_pok) begin
                rdata_nxt = {RAIL_POWER_OK, 2'h0};
            end else if (hit_current_limit) begin
                rdata_nxt = {current_limit_evt_r, 2'h0};
            end else if (hit_dly) begin
                rdata_nxt = {5'h00, dly_sel_r};
            end else if (hit_p2) begin
                rdata_nxt = {p2_en_r, p2_sel_r, 1'b0, p2_lvl_r};
            end
        end
    end

    // Read data register.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Power-good reset sequencing.
    ////////////////////////////////////////////////////////////////////////////

    rspc_dly_if dly ();

    // The timer runs while the sequence is waiting and all rails are good; any bad rail clears it.
    assign dly.start = (state_r == RSPC_ST_WAIT) && rail3_ok;
    assign dly.clear = !all_good;
    assign dly.sel   = dly_sel_r;

    rspc_dly_timer #(
        .BASE_CYC (BASE_CYC)
    ) u_timer (
        .clk (CLOCK),
        .rst (RST),
        .dly (dly.timer)
    );

    // Sequence: bad until rail 3 good, wait the delay, good while all rails hold.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RSPC_ST_BAD: begin
                if (rail3_ok) begin
                    state_nxt = RSPC_ST_WAIT;
                end
            end
            RSPC_ST_WAIT: begin
                if (!rail3_ok) begin
                    state_nxt = RSPC_ST_BAD;
                end else if (dly.done && all_good) begin
                    state_nxt = RSPC_ST_GOOD;
                end
            end
            RSPC_ST_GOOD: begin
                if (!all_good) begin
                    state_nxt = RSPC_ST_BAD;
                end
            end
        endcase
    end

    // State register.
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_r <= RSPC_ST_BAD;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign POWER_GOOD_RESET_OUT = released;

    ////////////////////////////////////////////////////////////////////////////
    // Pin 2 function multiplexing.
    ////////////////////////////////////////////////////////////////////////////

    // A function acts only after release and while enabled.
    wire fn_on     = released && p2_en_r;
    wire is_gpo    = (p2_sel_r == RSPC_FN_GPO1) || (p2_sel_r == RSPC_FN_GPO2);
    wire is_irq    = (p2_sel_r == RSPC_FN_IRQ);
    wire drive_gpo = fn_on && is_gpo;
    wire drive_irq = fn_on && is_irq;

    // Output pin: low for level 00, high for 01; interrupt drives low when pending.
    assign PIN2_OUT  = drive_gpo ? (p2_lvl_r == 2'h1) : !IRQ_PENDING;
    assign PIN2_OE_N = !(drive_gpo || drive_irq);

    // Before release the pin serves as a voltage select input.
    assign RAIL_VOLTAGE_SELECT_MODE = !released;

    // Input functions; external enable input codes map to nothing here.
    assign SLEEP_REQ        = fn_on && (p2_sel_r == RSPC_FN_SLEEP) && PIN2_IN;
    assign DEEP_SLEEP_REQ   = fn_on && (p2_sel_r == RSPC_FN_DSLEEP) && PIN2_IN;
    assign SW_RAIL12_ENABLE = fn_on && (p2_sel_r == RSPC_FN_SW12_EN) && PIN2_IN;
    assign POWER_DISABLE_IN = fn_on && (p2_sel_r == RSPC_FN_POWER_DISABLE_IN) && PIN2_IN;

endmodule // rspc_regs

// ### tb/rspc_regs_props.sv
/* Checker for the rail status and pin 2 configuration register bank.
   Assumes it is bound to every rspc_regs instance and sees its ports only. */
`timescale 1ns/1ps
module rspc_regs_chk #(parameter int BASE_CYC = 10000) (
    input wire logic       CLOCK, RST, REG_WR, REG_RD, IRQ_PENDING, PIN2_IN,
    input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
    input wire logic [5:0] RAIL_POWER_OK, RAIL_CURRENT_LIMIT,
    input wire logic       PIN2_OUT, PIN2_OE_N, POWER_GOOD_RESET_OUT, RAIL_VOLTAGE_SELECT_MODE,
    input wire logic       SLEEP_REQ, DEEP_SLEEP_REQ, SW_RAIL12_ENABLE, POWER_DISABLE_IN
);
    logic [7:0] cfg_r;
    wire  [3:0] req = {SLEEP_REQ, DEEP_SLEEP_REQ, SW_RAIL12_ENABLE, POWER_DISABLE_IN};
    wire        on  = POWER_GOOD_RESET_OUT && cfg_r[7];
    wire  [3:0] sel = cfg_r[6:3];
    wire        rd4 = REG_RD && REG_ADDR == 8'h04;
    // Shadow of the pin 2 configuration, so pin behaviour can be tied to it.
    always_ff @(posedge CLOCK or posedge RST)
        if (RST) cfg_r <= 8'h00;
        else if (REG_WR && REG_ADDR == 8'h06) cfg_r <= REG_WDATA;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    property p_status; REG_RD && REG_ADDR == 8'h03 |=> REG_RDATA == {$past(RAIL_POWER_OK), 2'b00}; endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_idle; !REG_RD |=> REG_RDATA == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_event; RAIL_CURRENT_LIMIT[5] ##1 rd4 |=> REG_RDATA[7]; endproperty
    a_event: assert property (p_event) else $error("event not latched");
    property p_clear; (rd4 && RAIL_CURRENT_LIMIT == 6'h00)[*2] |=> REG_RDATA == 8'h00; endproperty
    a_clear: assert property (p_clear) else $error("event not cleared");
    property p_drop; !(&RAIL_POWER_OK) |-> ##[1:2] !POWER_GOOD_RESET_OUT; endproperty
    a_drop: assert property (p_drop) else $error("good kept on rail drop");
    property p_rise; $rose(POWER_GOOD_RESET_OUT) |-> $past(&RAIL_POWER_OK); endproperty
    a_rise: assert property (p_rise) else $error("good without rails");
    property p_vsel; POWER_GOOD_RESET_OUT |-> !RAIL_VOLTAGE_SELECT_MODE; endproperty
    a_vsel: assert property (p_vsel) else $error("select mode after release");
    property p_hold; !POWER_GOOD_RESET_OUT |-> PIN2_OE_N && req == 4'h0; endproperty
    a_hold: assert property (p_hold) else $error("pin 2 active before release");
    property p_gpo; on && sel <= 4'h1 && !cfg_r[1] |-> !PIN2_OE_N && PIN2_OUT == cfg_r[0]; endproperty
    a_gpo: assert property (p_gpo) else $error("general output wrong");
    property p_irq; on && sel == 4'h2 |-> !PIN2_OE_N && PIN2_OUT == !IRQ_PENDING; endproperty
    a_irq: assert property (p_irq) else $error("interrupt output wrong");
    property p_in; on && sel inside {[3:6]} |-> PIN2_OE_N && req == ({3'b000, PIN2_IN} << (4'h6 - sel)); endproperty
    a_in: assert property (p_in) else $error("pin 2 input function wrong");
    property p_off; POWER_GOOD_RESET_OUT && (!cfg_r[7] || sel > 4'h6) |-> PIN2_OE_N && req == 4'h0; endproperty
    a_off: assert property (p_off) else $error("pin 2 active while off");
    c_good: cover property ($rose(POWER_GOOD_RESET_OUT));
    c_evt: cover property (rd4 ##1 REG_RDATA != 8'h00);
    c_drive: cover property (on && !PIN2_OE_N);
endmodule // rspc_regs_chk
bind rspc_regs rspc_regs_chk #(.BASE_CYC(BASE_CYC)) u_chk (.CLOCK(CLOCK), .RST(RST),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .IRQ_PENDING(IRQ_PENDING), .PIN2_IN(PIN2_IN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RAIL_POWER_OK(RAIL_POWER_OK), .RAIL_CURRENT_LIMIT(RAIL_CURRENT_LIMIT),
    .PIN2_OUT(PIN2_OUT), .PIN2_OE_N(PIN2_OE_N), .POWER_GOOD_RESET_OUT(POWER_GOOD_RESET_OUT),
    .RAIL_VOLTAGE_SELECT_MODE(RAIL_VOLTAGE_SELECT_MODE), .SLEEP_REQ(SLEEP_REQ),
    .DEEP_SLEEP_REQ(DEEP_SLEEP_REQ), .SW_RAIL12_ENABLE(SW_RAIL12_ENABLE),
    .POWER_DISABLE_IN(POWER_DISABLE_IN));

// ### tb/rspc_host.sv
/* Host model issuing one-cycle register writes and reads.
   Assumes the bank takes a request at the rising edge where its strobe is high. */
`timescale 1ns/1ps
module rspc_host (
    input  wire logic       clk,
    output      logic [7:0] addr,
    output      logic [7:0] wdata,
    output      logic       wr,
    output      logic       rd
);
    // Idle bus from time zero.
    initial begin
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // One write; the strobe stands for exactly one edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Reads n times back to back from one address.
    task automatic rd_reg(input logic [7:0] a, input int n);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        repeat (n) @(posedge clk);
        rd <= 1'b0;
    endtask
endmodule // rspc_host

// ### tb/rspc_regs_tb_top.sv
/* Self-checking bench for the register bank with a host model.
   Assumes the map header, package, interface and design are compiled first. */
`timescale 1ns/1ps
module rspc_regs_tb_top;
    logic       clock = 1'b0, rst = 1'b1, irq_pending = 1'b0, pin2_in = 1'b0, rd_d = 1'b0;
    logic [5:0] power_ok = 6'h00, current_limit = 6'h00;
    wire  [7:0] addr, wdata, rdata;
    wire        wr, rd, p2_out, p2_oe_n, pg, vsel, slp, dslp, sw12, pdis;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    int         n_fail = 0, cmp_count = 0, t;
    initial forever #25 clock = ~clock;
    rspc_host host (.clk(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
    rspc_regs #(.BASE_CYC(4)) dut (.CLOCK(clock), .RST(rst), .REG_ADDR(addr),
        .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .RAIL_POWER_OK(power_ok), .RAIL_CURRENT_LIMIT(current_limit), .IRQ_PENDING(irq_pending),
        .PIN2_IN(pin2_in), .PIN2_OUT(p2_out), .PIN2_OE_N(p2_oe_n),
        .POWER_GOOD_RESET_OUT(pg), .RAIL_VOLTAGE_SELECT_MODE(vsel), .SLEEP_REQ(slp),
        .DEEP_SLEEP_REQ(dslp), .SW_RAIL12_ENABLE(sw12), .POWER_DISABLE_IN(pdis));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Notes the expected read data, then issues the read.
    task automatic rd1(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd_reg(a, 1);
    endtask
    // Read data stands the cycle after the read edge; compare with oldest note.
    always @(posedge clock) begin
        rd_d <= rd;
        if (rd_d) check(rdata, exp_q.pop_front());
    end
    // Cuts a hang short.
    initial begin
        #(50 * 20000);
        n_fail++;
        close_out();
    end
    // Main sequence.
    initial begin
        v = $urandom(32'h45f796af);
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        check({pg, vsel, p2_oe_n}, 16'h3);
        rd1(8'h03, 8'h00);
        rd1(8'h04, 8'h00);
        rd1(8'h05, 8'h04);
        rd1(8'h06, 8'h00);
        host.wr_reg(8'h05, 8'hff);
        rd1(8'h05, 8'h07);
        rd1(8'h7e, 8'h00);
        for (int c = 0; c < 8; c++) begin
            power_ok <= 6'h00;
            host.wr_reg(8'h05, 8'(c));
            @(posedge clock);
            power_ok <= 6'h3f;
            t = 0;
            while (pg !== 1'b1 && t < 2000) begin
                @(posedge clock);
                t++;
            end
            check(16'(t >= (4 << c) && t <= (4 << c) + 3), 16'h1);
        end
        for (int s = 0; s < 10; s++) begin
            v = $urandom;
            irq_pending <= v[1];
            pin2_in <= v[2];
            host.wr_reg(8'h06, {s < 9, s < 9 ? 4'(s) : 4'h0, 1'b1, 1'b0, v[0]});
            @(posedge clock);
            if (s < 3) check({p2_oe_n, p2_out}, {1'b0, s < 2 ? v[0] : !v[1]});
            if (s >= 3 && s < 7) check({p2_oe_n, slp, dslp, sw12, pdis}, {1'b1, {3'b000, v[2]} << (6 - s)});
            if (s >= 7) check({p2_oe_n, slp, dslp, sw12, pdis}, 16'h10);
            rd1(8'h06, {s < 9, s < 9 ? 4'(s) : 4'h0, 2'b00, v[0]});
        end
        power_ok <= 6'h3e;
        repeat (3) @(posedge clock);
        check(pg, 16'h0);
        repeat (4) begin
            v = $urandom;
            power_ok <= v[7:2];
            current_limit <= v[5:0];
            @(posedge clock);
            current_limit <= 6'h00;
            rd1(8'h03, {v[7:2], 2'b00});
            host.wr_reg(8'h04, 8'hff);
            exp_q.push_back({v[5:0], 2'b00});
            exp_q.push_back(8'h00);
            host.rd_reg(8'h04, 2);
        end
        repeat (3) @(posedge clock);
        check(16'(exp_q.size()), 16'h0);
        close_out();
    end
endmodule // rspc_regs_tb_top
